// >>> include/interrupt_delay_defs.vh
// Purpose: constants for the interrupt delay mask control block
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef INTERRUPT_DELAY_DEFS_VH
`define INTERRUPT_DELAY_DEFS_VH

// command codes in the secondary accumulator
`define CMD_LOAD            16'h0001
`define CMD_SET_ONES        16'h0002
`define CMD_SET_ZEROS       16'h0003

// service selector
`define SVC_ALL             1'b0
`define SVC_PERIODIC        1'b1

// error identifiers written to the primary accumulator low word
`define ERR_ID_ALL          16'h1A48
`define ERR_ID_PERIODIC     16'h1A4B

// implemented bits of each mask
`define ALL_MASK_VALID      32'h0000000F
`define PER_MASK_VALID      32'h00000FF8

// reset values of the masks
`define ALL_MASK_RESET      32'h00000000
`define PER_MASK_RESET      16'h0000

// all-interrupt mask field positions
`define ALL_BIT_PERIODIC    0
`define ALL_BIT_CLOCK       1
`define ALL_BIT_PROCESS     2
`define ALL_BIT_DELAY       3

// periodic mask: first bit (10 ms source), number of periodic sources
`define PER_BIT_FIRST       3
`define NUM_PERIODIC        9

// source indices in the pending vector
`define SRC_CLOCK           9
`define SRC_PROCESS         10
`define SRC_DELAY           11
`define NUM_SOURCES         12
`define SRC_NONE            4'hF

`endif

// >>> hw/mask_command_alu.v
// Purpose: computes new delay mask, accumulator result and error for a command
// Assumes: purely combinational, inputs from same clock domain
// Notes:   result registered by the caller
`timescale 1ns/1ps
`include "interrupt_delay_defs.vh"

module mask_command_alu (
	// command
	input  wire        service,
	input  wire [15:0] code,
	input  wire [31:0] operand,
	// current masks
	input  wire [31:0] all_mask,
	input  wire [15:0] per_mask,
	// result
	output reg  [31:0] new_mask,
	output reg  [31:0] acc_result,
	output reg         error
);

	reg [31:0] valid;
	reg [31:0] cur;
	reg [15:0] err_id;

	always @* begin
		valid  = (service == `SVC_PERIODIC) ? `PER_MASK_VALID
		                                    : `ALL_MASK_VALID;
		cur    = (service == `SVC_PERIODIC) ? {16'h0000, per_mask}
		                                    : all_mask;
		err_id = (service == `SVC_PERIODIC) ? `ERR_ID_PERIODIC
		                                    : `ERR_ID_ALL;
		error  = 1'b0;
		case (code)
		`CMD_LOAD: begin
			new_mask   = operand;
			acc_result = operand;
		end
		`CMD_SET_ONES: begin
			new_mask   = cur | operand;
			acc_result = cur | operand;
		end
		`CMD_SET_ZEROS: begin
			new_mask   = cur | (~operand & valid);
			acc_result = cur | (~operand & valid);
		end
		default: begin
			new_mask   = cur;
			acc_result = operand;
			error      = 1'b1;
		end
		endcase
		if ((operand & ~valid) != 32'h00000000) begin
			error = 1'b1;
		end
		if (error) begin
			new_mask   = cur;
			acc_result = {operand[31:16], err_id};
		end
	end

endmodule

// >>> hw/interrupt_delay_mask_control.v
// Purpose: interrupt delay masks, pending latches and boundary dispatch
// Assumes: all inputs come from logic on clk; requests are one-cycle pulses
// Notes:   one command at a time, result one cycle after it is taken
//
// Summary of operation
// - code 1 loads selected mask, accumulator unchanged
// - code 2 sets mask bits where operand one
// - code 3 sets mask bits where operand zero
// - all-mask accumulator: word, or new mask
// - illegal command code raises an error
// - reserved operand bit set raises an error
// - error calls handler if loaded, else stop
// - error writes class error id to low word
// - periodic bits 3..11 delay 10ms..5s sources
// - periodic mask affects only periodic interrupts
// - delayed sources stay latched, never dispatched
// - running handler finishes despite new delay
// - delay removed: highest latched request goes next boundary if no handler runs
// - repeat periodic request while delayed: collision
// - status words mirror both delay masks
// - all-mask bits: periodic, clock, process, delay
`timescale 1ns/1ps
`include "interrupt_delay_defs.vh"

module interrupt_delay_mask_control (
	// clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// command from the processor core
	input  wire        cmd_valid,
	input  wire        cmd_service,
	input  wire [15:0] secondary_accumulator_low,
	input  wire [31:0] primary_accumulator,
	input  wire        runtime_handler_loaded,
	// command result
	output reg         result_valid,
	output reg  [31:0] result_accumulator,
	output reg         cmd_error,
	output reg         runtime_error_call,
	output reg         stop_state,
	// status words
	output reg  [31:0] all_delay_status_word,
	output reg  [15:0] periodic_delay_status_word,
	// interrupt requests
	input  wire [8:0]  periodic_req,
	input  wire        clock_time_req,
	input  wire        process_req,
	input  wire        delay_int_req,
	// program boundaries and handler progress
	input  wire        boundary,
	input  wire        handler_done,
	// dispatch
	output reg         dispatch_valid,
	output reg  [3:0]  dispatch_source,
	output reg         handler_active,
	output reg  [11:0] pending_flags,
	output reg         time_collision,
	output reg  [8:0]  collision_source
);

	// masks
	reg  [31:0] all_mask_r;
	reg  [31:0] all_mask_nxt;
	reg  [15:0] per_mask_r;
	reg  [15:0] per_mask_nxt;

	// pending state
	reg  [11:0] pending_r;
	wire [11:0] pending_nxt;
	wire [11:0] clear_vec;
	reg         active_r;
	reg         active_nxt;
	reg  [3:0]  dispatch_nxt;
	wire        dispatch_take;

	// command outcome
	reg  [31:0] result_acc_nxt;
	reg         stop_nxt;
	wire        take_error;
	wire        take_call;
	wire [8:0]  collide_vec;

	// alu results
	wire [31:0] alu_mask;
	wire [31:0] alu_acc;
	wire        alu_error;

	// request and delay vectors
	wire [11:0] req_vec;
	wire [11:0] delayed_vec;
	wire [11:0] eligible_vec;
	wire        cmd_take;
	wire [3:0]  pick;

	// highest index eligible source, none when empty
	function [3:0] pick_source;
		input [11:0] elig;
		integer      i;
		begin
			pick_source = `SRC_NONE;
			for (i = 0; i < `NUM_SOURCES; i = i + 1) begin
				if (elig[i]) begin
					pick_source = i[3:0];
				end
			end
		end
	endfunction

	// delay decode for one source index
	function source_delayed;
		input [3:0]  idx;
		input [31:0] amask;
		input [15:0] pmask;
		begin
			case (idx)
			4'h9: begin
				source_delayed = amask[`ALL_BIT_CLOCK];
			end
			4'hA: begin
				source_delayed = amask[`ALL_BIT_PROCESS];
			end
			4'hB: begin
				source_delayed = amask[`ALL_BIT_DELAY];
			end
			default: begin
				// periodic sources: all-mask bit or own bit
				source_delayed = amask[`ALL_BIT_PERIODIC] |
					pmask[idx + `PER_BIT_FIRST];
			end
			endcase
		end
	endfunction

	assign req_vec  = {delay_int_req, process_req, clock_time_req,
	                   periodic_req};
	assign cmd_take   = cmd_valid & ~stop_state;
	assign take_error = cmd_take & alu_error;
	assign take_call  = take_error & runtime_handler_loaded;

	// repeat request of a delayed, still latched source
	assign collide_vec = periodic_req & pending_r[8:0] &
	                     delayed_vec[8:0];

	// per-source delay state and pending latch
	genvar g;
	generate
		for (g = 0; g < `NUM_SOURCES; g = g + 1) begin : dly
			localparam [3:0] src_idx = g;
			assign delayed_vec[g] = source_delayed(src_idx, all_mask_r,
			                                       per_mask_r);
			assign clear_vec[g]   = dispatch_take &
			                        (pick == src_idx);
			// set wins over dispatch clear
			assign pending_nxt[g] = (pending_r[g] & ~clear_vec[g]) |
			                        req_vec[g];
		end
	endgenerate

	assign eligible_vec = pending_r & ~delayed_vec;
	assign pick         = pick_source(eligible_vec);

	mask_command_alu u_alu (
		.service    (cmd_service),
		.code       (secondary_accumulator_low),
		.operand    (primary_accumulator),
		.all_mask   (all_mask_r),
		.per_mask   (per_mask_r),
		.new_mask   (alu_mask),
		.acc_result (alu_acc),
		.error      (alu_error)
	);

	// all-interrupt mask update
	always @* begin
		all_mask_nxt = all_mask_r;
		if (cmd_take && !alu_error &&
		    cmd_service == `SVC_ALL) begin
			all_mask_nxt = alu_mask;
		end
	end

	// periodic mask update, low half of the result
	always @* begin
		per_mask_nxt = per_mask_r;
		if (cmd_take && !alu_error &&
		    cmd_service == `SVC_PERIODIC) begin
			per_mask_nxt = alu_mask[15:0];
		end
	end

	// dispatch at a boundary when no handler runs
	assign dispatch_take = boundary & ~active_r &
	                       (pick != `SRC_NONE);

	// handler activity and dispatched source
	always @* begin
		active_nxt   = active_r;
		dispatch_nxt = `SRC_NONE;
		if (handler_done) begin
			active_nxt = 1'b0;
		end
		if (dispatch_take) begin
			dispatch_nxt = pick;
			active_nxt   = 1'b1;
		end
	end

	// accumulator and stop state
	always @* begin
		result_acc_nxt = result_accumulator;
		stop_nxt       = stop_state;
		if (cmd_take) begin
			result_acc_nxt = alu_acc;
		end
		if (take_error && !runtime_handler_loaded) begin
			stop_nxt = 1'b1;
		end
	end

	// masks, pending latches, handler activity
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			all_mask_r <= `ALL_MASK_RESET;
			per_mask_r <= `PER_MASK_RESET;
			pending_r  <= 12'h000;
			active_r   <= 1'b0;
		end else begin
			all_mask_r <= all_mask_nxt;
			per_mask_r <= per_mask_nxt;
			pending_r  <= pending_nxt;
			active_r   <= active_nxt;
		end
	end

	// command result
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_valid       <= 1'b0;
			result_accumulator <= 32'h00000000;
			cmd_error          <= 1'b0;
			runtime_error_call <= 1'b0;
		end else begin
			result_valid       <= cmd_take;
			result_accumulator <= result_acc_nxt;
			cmd_error          <= take_error;
			runtime_error_call <= take_call;
		end
	end

	// stop state, left only by reset
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_state <= 1'b0;
		end else begin
			stop_state <= stop_nxt;
		end
	end

	// status words
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			all_delay_status_word      <= `ALL_MASK_RESET;
			periodic_delay_status_word <= `PER_MASK_RESET;
		end else begin
			all_delay_status_word      <= all_mask_nxt;
			periodic_delay_status_word <= per_mask_nxt;
		end
	end

	// dispatch strobe and source
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dispatch_valid  <= 1'b0;
			dispatch_source <= `SRC_NONE;
		end else begin
			dispatch_valid  <= dispatch_take;
			dispatch_source <= dispatch_nxt;
		end
	end

	// handler and pending view
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			handler_active <= 1'b0;
			pending_flags  <= 12'h000;
		end else begin
			handler_active <= active_nxt;
			pending_flags  <= pending_nxt;
		end
	end

	// time interrupt collision
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			time_collision   <= 1'b0;
			collision_source <= 9'h000;
		end else begin
			time_collision   <= |collide_vec;
			collision_source <= collide_vec;
		end
	end

endmodule

// >>> testbench/interrupt_delay_props.sv
// Purpose: port checks for the delay mask control
// Assumes: top module ports only
// Notes:   bound after the module
`timescale 1ns/1ps
module interrupt_delay_props (
	// clock, reset, command
	input logic        clk,
	input logic        reset_n,
	input logic        cmd_valid,
	input logic        cmd_service,
	// result
	input logic        result_valid,
	input logic [31:0] result_accumulator,
	input logic        cmd_error,
	input logic        runtime_error_call,
	input logic        stop_state,
	input logic [31:0] all_delay_status_word,
	input logic [15:0] periodic_delay_status_word,
	// dispatch
	input logic        boundary,
	input logic        dispatch_valid,
	input logic [3:0]  dispatch_source,
	input logic        handler_active
);
	wire [31:0] all_w = all_delay_status_word;
	wire [15:0] per_w = periodic_delay_status_word;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_take;
		cmd_valid && !stop_state;
	endsequence
	a_result_next: assert property (s_take |=> result_valid)
		else $error("no result after command");
	a_refused_stop: assert property (stop_state |=> !result_valid)
		else $error("command taken while stopped");
	a_stop_held: assert property (stop_state |=> stop_state)
		else $error("stop left without reset");
	a_error_route: assert property (cmd_error |->
		stop_state != runtime_error_call) else $error("bad error route");
	a_error_id: assert property (cmd_error |->
		result_accumulator[15:0] == ($past(cmd_service) ? 16'h1A4B
		: 16'h1A48)) else $error("wrong error id");
	a_acc_mirror: assert property (result_valid && !cmd_error |->
		result_accumulator == ($past(cmd_service) ? {16'h0, per_w}
		: all_w)) else $error("accumulator not new mask");
	a_mask_kept: assert property (cmd_error |->
		$stable(all_w) && $stable(per_w)) else $error("mask changed");
	a_delay_hold: assert property (dispatch_valid &&
		dispatch_source < 4'h9 |-> !$past(all_w[0]))
		else $error("delayed periodic dispatched");
	a_periodic_hold: assert property (dispatch_valid &&
		dispatch_source < 4'h9 |-> ($past(per_w) &
		(16'h0008 << dispatch_source)) == 16'h0000)
		else $error("delayed periodic source dispatched");
	a_dispatch_run: assert property (dispatch_valid |->
		handler_active && $past(boundary)) else $error("bad dispatch");
endmodule
bind interrupt_delay_mask_control interrupt_delay_props u_props (
	.clk, .reset_n, .cmd_valid, .cmd_service, .result_valid,
	.result_accumulator, .cmd_error, .runtime_error_call, .stop_state,
	.all_delay_status_word, .periodic_delay_status_word, .boundary,
	.dispatch_valid, .dispatch_source, .handler_active);

// >>> testbench/user_program.sv
// Purpose: user program issuing delay commands
// Assumes: drives on the falling edge
// Notes:   one command per call
`timescale 1ns/1ps
module user_program (
	// clock
	input  wire        clk,
	// command
	output reg         cmd_valid,
	output reg         cmd_service,
	output reg  [15:0] code,
	output reg  [31:0] acc
);
	initial begin
		cmd_valid = 1'b0;
		cmd_service = 1'b0;
		code = 16'h0;
		acc = 32'h0;
	end
	// operand given as is; reserved bits only set on purpose
	task issue(input s, input [15:0] c, input [31:0] a);
		begin
			@(negedge clk);
			cmd_valid = 1'b1;
			cmd_service = s;
			code = c;
			acc = a;
			@(negedge clk);
			cmd_valid = 1'b0;
			acc = ~a;
		end
	endtask
endmodule

// >>> testbench/interrupt_delay_mask_control_bench.sv
// Purpose: bench for the delay mask control
// Assumes: inputs change on the falling edge
// Notes:   table of commands, then dispatch and stop cases
`timescale 1ns/1ps
module interrupt_delay_mask_control_bench;
	reg clk = 0, reset_n = 0, loaded = 1;
	reg [13:0] req = 0;
	wire cmd_valid, cmd_service, result_valid, cmd_error;
	wire runtime_error_call, stop_state, dispatch_valid, handler_active;
	wire time_collision;
	wire [15:0] code, periodic_delay_status_word;
	wire [31:0] acc, result_accumulator, all_delay_status_word;
	wire [3:0] dispatch_source;
	wire [11:0] pending_flags;
	wire [8:0] collision_source;
	integer bad_count = 0, num_checks = 0, cycles = 0, i;
	reg [81:0] rows [0:12];
	`define CHK(n, e, s) begin num_checks = num_checks + 1; \
		if ((s) !== (e)) begin bad_count = bad_count + 1; \
		$display("unexpected %s exp %h got %h", n, e, s); end end
	always #25 clk = ~clk;
	user_program u_prog (.clk, .cmd_valid, .cmd_service, .code, .acc);
	interrupt_delay_mask_control u_dut (.clk, .reset_n, .cmd_valid,
		.cmd_service, .secondary_accumulator_low(code),
		.primary_accumulator(acc), .runtime_handler_loaded(loaded),
		.result_valid, .result_accumulator, .cmd_error,
		.runtime_error_call, .stop_state, .all_delay_status_word,
		.periodic_delay_status_word, .periodic_req(req[13:5]),
		.clock_time_req(req[4]), .process_req(req[3]),
		.delay_int_req(req[2]), .boundary(req[1]),
		.handler_done(req[0]), .dispatch_valid, .dispatch_source,
		.handler_active, .pending_flags, .time_collision,
		.collision_source);
	task fire(input [13:0] v);
		begin
			@(negedge clk) req = v;
			@(negedge clk) req = 14'h0;
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 400) begin
			bad_count = bad_count + 1;
			complete_run;
		end
	end
	initial begin
		rows[0] = {1'b0, 16'h1, 32'h5, 32'h5, 1'b0};
		rows[1] = {1'b0, 16'h2, 32'h2, 32'h7, 1'b0};
		rows[2] = {1'b0, 16'h1, 32'h0, 32'h0, 1'b0};
		rows[3] = {1'b0, 16'h3, 32'hE, 32'h1, 1'b0};
		rows[4] = {1'b0, 16'h4, 32'h12345678, 32'h12341A48, 1'b1};
		rows[5] = {1'b0, 16'h1, 32'h10, 32'h1A48, 1'b1};
		rows[6] = {1'b0, 16'h2, 32'h0, 32'h1, 1'b0};
		rows[7] = {1'b1, 16'h1, 32'h8, 32'h8, 1'b0};
		rows[8] = {1'b1, 16'h3, 32'hFE8, 32'h18, 1'b0};
		rows[9] = {1'b1, 16'h2, 32'hFF8, 32'hFF8, 1'b0};
		rows[10] = {1'b1, 16'h1, 32'h4, 32'h1A4B, 1'b1};
		rows[11] = {1'b1, 16'h0, 32'h0, 32'h1A4B, 1'b1};
		rows[12] = {1'b1, 16'h1, 32'h0, 32'h0, 1'b0};
		repeat (3) @(negedge clk);
		reset_n = 1;
		for (i = 0; i < 13; i = i + 1) begin
			u_prog.issue(rows[i][81], rows[i][80:65], rows[i][64:33]);
			`CHK("valid", 1'b1, result_valid)
			`CHK("acc", rows[i][32:1], result_accumulator)
			`CHK("err", rows[i][0], cmd_error)
			`CHK("call", rows[i][0], runtime_error_call)
		end
		`CHK("all", 32'h1, all_delay_status_word)
		u_prog.issue(1, 16'h1, 32'h8);
		`CHK("per", 16'h8, periodic_delay_status_word)
		fire(14'h30);
		`CHK("pend", 12'h201, pending_flags)
		fire(14'h2);
		`CHK("clk src", 4'h9, dispatch_source)
		fire(14'h20);
		`CHK("coll", 9'h1, collision_source)
		`CHK("coll flag", 1'b1, time_collision)
		u_prog.issue(0, 16'h1, 32'h6);
		`CHK("run", 1'b1, handler_active)
		fire(14'h1);
		fire(14'h8);
		fire(14'h2);
		`CHK("held", 1'b0, dispatch_valid)
		u_prog.issue(0, 16'h1, 32'h0);
		u_prog.issue(1, 16'h1, 32'h0);
		fire(14'h2);
		`CHK("prc src", 4'hA, dispatch_source)
		fire(14'h1);
		fire(14'h2);
		`CHK("per src", 4'h0, dispatch_source)
		fire(14'h1);
		u_prog.issue(0, 16'h1, 32'h8);
		fire(14'h4);
		fire(14'h2);
		`CHK("dly held", 1'b0, dispatch_valid)
		`CHK("dly pend", 12'h800, pending_flags)
		u_prog.issue(0, 16'h1, 32'h0);
		fire(14'h2);
		`CHK("dly src", 4'hB, dispatch_source)
		loaded = 0;
		u_prog.issue(0, 16'h2, 32'h10);
		`CHK("stop", 1'b1, stop_state)
		u_prog.issue(0, 16'h1, 32'h1);
		`CHK("refused", 1'b0, result_valid)
		reset_n = 0;
		@(negedge clk);
		`CHK("rst src", 4'hF, dispatch_source)
		`CHK("rst stop", 1'b0, stop_state)
		complete_run;
	end
endmodule
